// [verilog/actrl_pkg.sv]
// Package with register map, field positions, reset values and types of the converter control block
package actrl_pkg;

    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register indices; each index times four gives the byte address
    localparam logic [7:0] IDX_CTRL_B  = 8'h03;
    localparam logic [7:0] IDX_RES_LO  = 8'h04;
    localparam logic [7:0] IDX_RES_HI  = 8'h05;
    localparam logic [7:0] IDX_CTRL_A  = 8'h06;
    localparam logic [7:0] IDX_CHAN    = 8'h07;
    localparam logic [7:0] IDX_DIS     = 8'h14;

    // Byte addresses on the bus
    localparam logic [7:0] ADDR_CTRL_B = {IDX_CTRL_B[5:0], 2'b00};
    localparam logic [7:0] ADDR_RES_LO = {IDX_RES_LO[5:0], 2'b00};
    localparam logic [7:0] ADDR_RES_HI = {IDX_RES_HI[5:0], 2'b00};
    localparam logic [7:0] ADDR_CTRL_A = {IDX_CTRL_A[5:0], 2'b00};
    localparam logic [7:0] ADDR_CHAN   = {IDX_CHAN[5:0], 2'b00};
    localparam logic [7:0] ADDR_DIS    = {IDX_DIS[5:0], 2'b00};

    // Control A fields
    localparam int A_ENABLE   = 7;
    localparam int A_START    = 6;
    localparam int A_AUTO     = 5;
    localparam int A_DONE     = 4;
    localparam int A_IRQ_EN   = 3;
    localparam int A_DIV_LSB  = 0;

    // Left alignment bit of the channel register
    localparam int CHAN_LEFT  = 5;

    // Control B fields
    localparam int B_BIPOLAR  = 7;
    localparam int B_SWAP     = 5;
    localparam int B_TRIG_LSB = 0;
    localparam logic [7:0] B_WMASK   = 8'hE7;

    // Digital input disable mask
    localparam logic [7:0] DIS_WMASK = 8'h3F;

    // Reset values
    localparam logic [7:0] RST_REG   = 8'h00;

    // Result shaping
    localparam int RES_W  = 10;
    localparam int DIFF_W = 11;
    localparam int PIN_N  = 6;
    localparam int DIV_W  = 7;
    localparam logic signed [11:0] UNI_MAX = 12'sh3FF;
    localparam logic signed [11:0] BIP_MAX = 12'sh1FF;
    localparam logic signed [11:0] BIP_MIN = -12'sh200;

    // Auto trigger sources
    typedef enum logic [2:0] {
        TRIG_FREE   = 3'b000,
        TRIG_COMP   = 3'b001,
        TRIG_EXT0   = 3'b010,
        TRIG_CMPA   = 3'b011,
        TRIG_OVF    = 3'b100,
        TRIG_CMPB   = 3'b101,
        TRIG_PINCHG = 3'b110,
        TRIG_NONE   = 3'b111
    } actrl_trig_t;

    // Main block state
    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [7:0]        ctrl_a;
        logic [7:0]        chan;
        logic [7:0]        ctrl_b;
        logic [7:0]        dis;
        logic [9:0]        result;
        logic              locked;
        logic              busy;
        logic              start_pulse;
        logic              trig_prev;
        logic [5:0]        pin_s1;
        logic [5:0]        pin_s2;
        logic [5:0]        pin_read;
    } actrl_state_t;

    // Prescaler state
    typedef struct packed {
        logic [6:0]        cnt;
        logic              clk_out;
    } actrl_div_state_t;

endpackage

// [verilog/actrl_prescale.sv]
// Converter clock prescaler driven by the three-bit divider select
module actrl_prescale #(
    parameter int CNT_W = actrl_pkg::DIV_W
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            div_clk
);

    actrl_pkg::actrl_div_state_t st;
    actrl_pkg::actrl_div_state_t next_st;
    logic [2:0]                  bit_idx;

    // Codes 0 and 1 both tap bit 0 (divide by 2), code 7 taps bit 6 (divide by 128)
    always_comb begin
        bit_idx = (sel == 3'h0) ? 3'h0 : sel - 3'h1;
        next_st = st;
        if (run) begin
            next_st.cnt     = st.cnt + 7'h01;
            next_st.clk_out = next_st.cnt[bit_idx];
        end else begin
            next_st.cnt     = 7'h00;
            next_st.clk_out = 1'b0;
        end
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign div_clk = st.clk_out;

endmodule

// [verilog/actrl_top.sv]
// Converter control block: registers, result formatting, read lock, auto trigger and input disable
//
// Register access over APB was decided locally.
module actrl_top (
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             CONV_CLK,
    output logic             CONV_ENABLE,
    output logic             CONV_START,
    output logic             CONV_BIPOLAR,
    output logic             CONV_SWAP,
    output logic      [3:0]  CONV_CHANNEL,
    input  wire logic        CONV_DONE,
    input  wire logic [10:0] CONV_DIFF,
    input  wire logic [6:1]  TRIG_FLAGS,
    input  wire logic [5:0]  PIN_RAW,
    output logic      [5:0]  PIN_READ,
    output logic      [5:0]  INBUF_OFF
);

    actrl_pkg::actrl_state_t st;
    actrl_pkg::actrl_state_t next_st;
    logic                    div_clk;
    logic                    enable;
    logic                    left;
    logic [7:0]              res_lo;
    logic [7:0]              res_hi;
    logic [7:0]              rd_val;
    logic                    mapped;
    logic                    access;
    logic                    done_xfer;
    logic                    trig_level;
    logic                    trig_edge;
    logic                    start_req;
    logic                    restart;
    actrl_pkg::actrl_trig_t  trig_sel;

    // Shapes the signed difference into the stored ten-bit result
    function automatic logic [9:0] shape(input logic [10:0] d, input logic bip, input logic swap);
        logic signed [11:0] v;
        logic [9:0]         r;
        v = $signed({d[10], d});
        if (swap) begin
            v = -v;
        end
        if (bip) begin
            v = v >>> 1;
            if (v > actrl_pkg::BIP_MAX) begin
                r = actrl_pkg::BIP_MAX[9:0];
            end else if (v < actrl_pkg::BIP_MIN) begin
                r = actrl_pkg::BIP_MIN[9:0];
            end else begin
                r = v[9:0];
            end
        end else begin
            if (v < 12'sh000) begin
                r = 10'h000;
            end else if (v > actrl_pkg::UNI_MAX) begin
                r = actrl_pkg::UNI_MAX[9:0];
            end else begin
                r = v[9:0];
            end
        end
        return r;
    endfunction

    // Prescaler runs only while the converter is enabled
    actrl_prescale #(
        .CNT_W (actrl_pkg::DIV_W)
    ) u_prescale (
        .clk     (MCLK),
        .rst_n   (RSTN),
        .ce      (CE),
        .run     (st.ctrl_a[actrl_pkg::A_ENABLE]),
        .sel     (st.ctrl_a[actrl_pkg::A_DIV_LSB +: 3]),
        .div_clk (div_clk)
    );

    // Result presentation follows the alignment bit with no delay
    always_comb begin
        left = st.chan[actrl_pkg::CHAN_LEFT];
        if (left) begin
            res_hi = st.result[9:2];
            res_lo = {st.result[1:0], 6'h00};
        end else begin
            res_hi = {6'h00, st.result[9:8]};
            res_lo = st.result[7:0];
        end
    end

    // Read multiplexer and address decode
    always_comb begin
        mapped = 1'b1;
        case (PADDR)
            actrl_pkg::ADDR_CTRL_A: rd_val = {st.ctrl_a[7], st.busy, st.ctrl_a[5:0]};
            actrl_pkg::ADDR_CHAN:   rd_val = st.chan;
            actrl_pkg::ADDR_CTRL_B: rd_val = st.ctrl_b & actrl_pkg::B_WMASK;
            actrl_pkg::ADDR_RES_LO: rd_val = res_lo;
            actrl_pkg::ADDR_RES_HI: rd_val = res_hi;
            actrl_pkg::ADDR_DIS:    rd_val = st.dis & actrl_pkg::DIS_WMASK;
            default: begin
                rd_val = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    // Trigger source selection and edge detection
    always_comb begin
        trig_sel = actrl_pkg::actrl_trig_t'(st.ctrl_b[actrl_pkg::B_TRIG_LSB +: 3]);
        case (trig_sel)
            actrl_pkg::TRIG_FREE:   trig_level = 1'b0;
            actrl_pkg::TRIG_COMP:   trig_level = TRIG_FLAGS[1];
            actrl_pkg::TRIG_EXT0:   trig_level = TRIG_FLAGS[2];
            actrl_pkg::TRIG_CMPA:   trig_level = TRIG_FLAGS[3];
            actrl_pkg::TRIG_OVF:    trig_level = TRIG_FLAGS[4];
            actrl_pkg::TRIG_CMPB:   trig_level = TRIG_FLAGS[5];
            actrl_pkg::TRIG_PINCHG: trig_level = TRIG_FLAGS[6];
            default:                trig_level = 1'b0;
        endcase
        // Previous level is of whatever was selected, so a switch can form an edge
        trig_edge = trig_level & ~st.trig_prev;
    end

    // Next state
    always_comb begin
        next_st             = st;
        next_st.start_pulse = 1'b0;
        access              = PSEL & PENABLE;
        done_xfer           = access & st.pready;
        start_req           = 1'b0;
        enable              = st.ctrl_a[actrl_pkg::A_ENABLE];

        // Bus answer prepared in the first access cycle
        if (access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~mapped;
            next_st.prdata  = {24'h000000, rd_val};
        end

        // Effects at the edge that completes the transfer
        if (done_xfer) begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            if (PWRITE) begin
                case (PADDR)
                    actrl_pkg::ADDR_CTRL_A: begin
                        next_st.ctrl_a[7]   = PWDATA[actrl_pkg::A_ENABLE];
                        next_st.ctrl_a[5]   = PWDATA[actrl_pkg::A_AUTO];
                        next_st.ctrl_a[3:0] = PWDATA[3:0];
                        if (PWDATA[actrl_pkg::A_DONE]) begin
                            next_st.ctrl_a[actrl_pkg::A_DONE] = 1'b0;
                        end
                        start_req = PWDATA[actrl_pkg::A_START];
                    end
                    actrl_pkg::ADDR_CHAN:   next_st.chan   = PWDATA[7:0];
                    actrl_pkg::ADDR_CTRL_B: next_st.ctrl_b = PWDATA[7:0] & actrl_pkg::B_WMASK;
                    actrl_pkg::ADDR_DIS:    next_st.dis    = PWDATA[7:0] & actrl_pkg::DIS_WMASK;
                    default: begin
                    end
                endcase
            end else begin
                if (PADDR == actrl_pkg::ADDR_RES_LO) begin
                    next_st.locked = 1'b1;
                end
                if (PADDR == actrl_pkg::ADDR_RES_HI) begin
                    next_st.locked = 1'b0;
                end
            end
        end

        // Auto trigger only counts while enabled
        next_st.trig_prev = trig_level;
        if (st.ctrl_a[actrl_pkg::A_AUTO] && trig_edge) begin
            start_req = 1'b1;
        end

        // Completion: unless locked, load the result and raise the done flag
        restart = 1'b0;
        if (CONV_DONE && st.busy) begin
            next_st.busy = 1'b0;
            if (!next_st.locked) begin
                next_st.result = shape(CONV_DIFF, st.ctrl_b[actrl_pkg::B_BIPOLAR],
                                       st.ctrl_b[actrl_pkg::B_SWAP]);
                next_st.ctrl_a[actrl_pkg::A_DONE] = 1'b1;
            end
            restart = st.ctrl_a[actrl_pkg::A_AUTO] && (trig_sel == actrl_pkg::TRIG_FREE);
        end

        // Start a conversion when idle and enabled
        if ((start_req || restart) && next_st.ctrl_a[actrl_pkg::A_ENABLE] && !next_st.busy) begin
            next_st.busy        = 1'b1;
            next_st.start_pulse = 1'b1;
        end

        // Turning the converter off ends any conversion
        if (!enable && !next_st.ctrl_a[actrl_pkg::A_ENABLE]) begin
            next_st.busy        = 1'b0;
            next_st.start_pulse = 1'b0;
        end

        // Pin synchronisers and gated pin readback
        next_st.pin_s1   = PIN_RAW;
        next_st.pin_s2   = st.pin_s1;
        next_st.pin_read = st.pin_s2 & ~st.dis[5:0];
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            st <= '0;
        end else if (CE) begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign PRDATA       = st.prdata;
    assign PREADY       = st.pready;
    assign PSLVERR      = st.pslverr;
    assign CONV_CLK     = div_clk;
    assign CONV_ENABLE  = st.ctrl_a[actrl_pkg::A_ENABLE];
    assign CONV_START   = st.start_pulse;
    assign CONV_BIPOLAR = st.ctrl_b[actrl_pkg::B_BIPOLAR];
    assign CONV_SWAP    = st.ctrl_b[actrl_pkg::B_SWAP];
    assign CONV_CHANNEL = st.chan[3:0];
    assign PIN_READ     = st.pin_read;
    assign INBUF_OFF    = st.dis[5:0];

endmodule

// [bench/actrl_core_model.sv]
// Behavioural model of the analog front end and conversion core
module actrl_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        start,
    input  wire logic [10:0] value,
    input  wire logic [7:0]  lat,
    output logic             done,
    output logic      [10:0] diff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic       busy;

    // Conversion time counter, aborted when the converter is switched off
    always_ff @(posedge clk) begin
        if (!rst_n || !enable) begin
            busy <= 1'b0;
            done <= 1'b0;
            cnt  <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                cnt  <= lat;
            end else if (busy) begin
                cnt  <= cnt - 8'h01;
                busy <= cnt != 8'h00;
                done <= cnt == 8'h00;
            end
        end
    end

    // Difference is only valid with the done pulse, garbage otherwise
    assign diff = done ? value : ~value;
endmodule

// [bench/actrl_chk_sva.sv]
// Port-level assertion checker of the converter control block
module actrl_chk (
    input logic        MCLK,
    input logic        RSTN,
    input logic        CE,
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [7:0]  PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic        PREADY,
    input logic        PSLVERR,
    input logic        CONV_CLK,
    input logic        CONV_ENABLE,
    input logic        CONV_START,
    input logic        CONV_BIPOLAR,
    input logic        CONV_SWAP,
    input logic [3:0]  CONV_CHANNEL,
    input logic        CONV_DONE,
    input logic [10:0] CONV_DIFF,
    input logic [6:1]  TRIG_FLAGS,
    input logic [5:0]  PIN_RAW,
    input logic [5:0]  PIN_READ,
    input logic [5:0]  INBUF_OFF
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    // Bus answer timing and framing
    a_ready_on_time: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE && CE) |=> PREADY)
        else $error("answer not one cycle after access");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_error_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error outside an answer");
    a_data_high_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    // Register contents seen on reads and gated pin readback
    a_reserved_zero: assert property (PREADY && !PWRITE && PADDR == actrl_pkg::ADDR_CTRL_B |-> PRDATA[4:3] == 2'b00)
        else $error("reserved bits read nonzero");
    a_pin_forced_low: assert property ($stable(INBUF_OFF) |-> (PIN_READ & INBUF_OFF) == 6'h00)
        else $error("disabled pin reads high");
    // Converter side
    a_start_single: assert property (CONV_START |=> !CONV_START)
        else $error("start longer than one cycle");
    a_start_enabled: assert property (CONV_START |-> CONV_ENABLE)
        else $error("start while disabled");
    a_clk_idle_off: assert property (!CONV_ENABLE && !$past(CONV_ENABLE) |-> !CONV_CLK)
        else $error("converter clock runs while disabled");
endmodule

bind actrl_top actrl_chk actrl_chk_i (
    .MCLK, .RSTN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .CONV_CLK, .CONV_ENABLE, .CONV_START, .CONV_BIPOLAR, .CONV_SWAP, .CONV_CHANNEL, .CONV_DONE,
    .CONV_DIFF, .TRIG_FLAGS, .PIN_RAW, .PIN_READ, .INBUF_OFF
);

// [bench/tb_top.sv]
// Self-checking testbench of the converter control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK = 1'b0, RSTN = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic [6:1]  TRIG_FLAGS = 6'h00;
    logic [5:0]  PIN_RAW = 6'h00;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, CONV_CLK, CONV_ENABLE, CONV_START, CONV_BIPOLAR, CONV_SWAP, CONV_DONE;
    logic [3:0]  CONV_CHANNEL;
    logic [10:0] CONV_DIFF;
    logic [5:0]  PIN_READ, INBUF_OFF;
    logic [10:0] conv_value = 11'h000;
    logic [7:0]  lat = 8'h00;
    logic        clk_q = 1'b0;
    int          failures = 0, tests_run = 0, starts = 0, dones = 0, gap = 0, rise_gap = 0, i, s;
    logic [7:0]  t_cb [7] = '{8'h80, 8'h80, 8'h80, 8'h20, 8'h20, 8'h00, 8'h00};
    logic [10:0] t_in [7] = '{11'h79C, 11'h258, 11'h400, 11'h6D4, 11'h400, 11'h7F0, 11'h2B5};
    logic [9:0]  t_ex [7] = '{10'h3CE, 10'h12C, 10'h200, 10'h12C, 10'h3FF, 10'h000, 10'h2B5};

    actrl_top actrl_top_i (.MCLK, .RSTN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .CONV_CLK, .CONV_ENABLE, .CONV_START, .CONV_BIPOLAR, .CONV_SWAP, .CONV_CHANNEL,
        .CONV_DONE, .CONV_DIFF, .TRIG_FLAGS, .PIN_RAW, .PIN_READ, .INBUF_OFF);
    actrl_core_model actrl_core_model_i (.clk(MCLK), .rst_n(RSTN), .enable(CONV_ENABLE), .start(CONV_START),
        .value(conv_value), .lat(lat), .done(CONV_DONE), .diff(CONV_DIFF));

    always #10 MCLK = ~MCLK;

    // Start and done counters, converter clock period in system cycles
    always @(posedge MCLK) begin
        clk_q <= CONV_CLK;
        if (CONV_START === 1'b1) starts <= starts + 1;
        if (CONV_DONE === 1'b1) dones <= dones + 1;
        if (CONV_CLK === 1'b1 && clk_q === 1'b0) begin
            rise_gap <= gap;
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end

    task automatic close_out();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h000000, wd};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(what, exp, r);
    endtask

    // Single conversion started by software, waits for the core to finish
    task automatic conv(input logic [10:0] v, input logic [7:0] b);
        int n, d0;
        d0 = dones;
        conv_value <= v;
        wr(actrl_pkg::ADDR_CTRL_B, b);
        wr(actrl_pkg::ADDR_CTRL_A, 8'hC0);
        for (n = 0; n < 400 && dones == d0; n++) @(posedge MCLK);
        chk("conversion finished", 32'h1, {31'h0, dones != d0});
        repeat (2) @(posedge MCLK);
    endtask

    task automatic res(input logic [9:0] r);
        rd("result low", actrl_pkg::ADDR_RES_LO, {24'h000000, r[7:0]});
        rd("result high", actrl_pkg::ADDR_RES_HI, {30'h0, r[9:8]});
    endtask

    initial begin
        repeat (20000) @(posedge MCLK);
        failures++;
        close_out();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        repeat (12) @(posedge MCLK);
        RSTN <= 1'b1;
        // Reset values, unmapped address, masked bits
        rd("control b reset", actrl_pkg::ADDR_CTRL_B, 32'h0);
        rd("low reset", actrl_pkg::ADDR_RES_LO, 32'h0);
        rd("high reset", actrl_pkg::ADDR_RES_HI, 32'h0);
        rd("disable reset", actrl_pkg::ADDR_DIS, 32'h0);
        apb(1'b0, 8'hF0, 8'h00, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        wr(actrl_pkg::ADDR_CTRL_B, 8'hFF);
        rd("control b mask", actrl_pkg::ADDR_CTRL_B, 32'hE7);
        wr(actrl_pkg::ADDR_DIS, 8'hFF);
        rd("disable mask", actrl_pkg::ADDR_DIS, 32'h3F);
        PIN_RAW <= 6'h3F;
        repeat (5) @(posedge MCLK);
        chk("pin read all off", 32'h0, {26'h0, PIN_READ});
        chk("buffer off", 32'h3F, {26'h0, INBUF_OFF});
        wr(actrl_pkg::ADDR_DIS, 8'h03);
        repeat (5) @(posedge MCLK);
        chk("pin read partly", 32'h3C, {26'h0, PIN_READ});
        // Every prescaler code
        for (i = 0; i < 8; i++) begin
            wr(actrl_pkg::ADDR_CTRL_A, 8'h80 | 8'(i));
            repeat (300) @(posedge MCLK);
            chk("divider period", (i < 2) ? 2 : (1 << i), rise_gap);
        end
        // Clock enable low freezes the prescaler
        CE <= 1'b0;
        repeat (150) @(posedge MCLK);
        chk("frozen divider", 32'h1, {31'h0, gap > 140});
        CE <= 1'b1;
        wr(actrl_pkg::ADDR_CTRL_A, 8'h80);
        // Gain modes, swap and saturation with prompt and slow core
        for (i = 0; i < 7; i++) begin
            lat <= 8'(i * 9);
            conv(t_in[i], t_cb[i]);
            chk("bipolar level", {31'h0, t_cb[i][7]}, {31'h0, CONV_BIPOLAR});
            chk("swap level", {31'h0, t_cb[i][5]}, {31'h0, CONV_SWAP});
            rd("done flag set", actrl_pkg::ADDR_CTRL_A, 32'h90);
            res(t_ex[i]);
        end
        // Alignment switch and done flag clear
        wr(actrl_pkg::ADDR_CHAN, 8'h2B);
        rd("left low", actrl_pkg::ADDR_RES_LO, 32'h40);
        chk("channel out", 32'hB, {28'h0, CONV_CHANNEL});
        rd("left high", actrl_pkg::ADDR_RES_HI, 32'hAD);
        wr(actrl_pkg::ADDR_CHAN, 8'h00);
        rd("right high", actrl_pkg::ADDR_RES_HI, 32'h02);
        wr(actrl_pkg::ADDR_CTRL_A, 8'h90);
        rd("done flag cleared", actrl_pkg::ADDR_CTRL_A, 32'h80);
        // Read lock across a finishing conversion
        rd("locked low", actrl_pkg::ADDR_RES_LO, 32'hB5);
        conv(11'h011, 8'h00);
        rd("locked no flag", actrl_pkg::ADDR_CTRL_A, 32'h80);
        res(10'h2B5);
        conv(11'h011, 8'h00);
        res(10'h011);
        // Auto trigger: ignored when off, every source, switching
        lat <= 8'h05;
        wr(actrl_pkg::ADDR_CTRL_B, 8'h01);
        s = starts;
        TRIG_FLAGS <= 6'h01;
        repeat (20) @(posedge MCLK);
        chk("trigger ignored", s, starts);
        TRIG_FLAGS <= 6'h00;
        wr(actrl_pkg::ADDR_CTRL_A, 8'hA0);
        for (i = 1; i < 7; i++) begin
            wr(actrl_pkg::ADDR_CTRL_B, 8'(i));
            s = starts;
            TRIG_FLAGS <= ~(6'h01 << (i - 1));
            repeat (20) @(posedge MCLK);
            TRIG_FLAGS <= 6'h3F;
            repeat (30) @(posedge MCLK);
            TRIG_FLAGS <= 6'h00;
            chk("selected source start", s + 1, starts);
        end
        wr(actrl_pkg::ADDR_CTRL_B, 8'h07);
        s = starts;
        TRIG_FLAGS <= 6'h3F;
        repeat (20) @(posedge MCLK);
        chk("unused code no start", s, starts);
        TRIG_FLAGS <= 6'h02;
        s = starts;
        wr(actrl_pkg::ADDR_CTRL_B, 8'h02);
        repeat (30) @(posedge MCLK);
        chk("switch to set flag", s + 1, starts);
        s = starts;
        wr(actrl_pkg::ADDR_CTRL_B, 8'h00);
        repeat (30) @(posedge MCLK);
        chk("switch to free run", s, starts);
        wr(actrl_pkg::ADDR_CTRL_A, 8'hE0);
        repeat (60) @(posedge MCLK);
        wr(actrl_pkg::ADDR_CTRL_A, 8'h80);
        chk("free run restarts", 32'h1, {31'h0, starts - s > 3});
        repeat (20) @(posedge MCLK);
        close_out();
    end
endmodule
